// File: common/pfr_pkg.sv
package pfr_pkg;

    // I/O port map
    localparam logic [7:0]  PFR_PORT_ADDR       = 8'hd4;
    localparam int          PFR_SENSE_BIT       = 0;
    localparam logic [7:0]  PFR_RDATA_RESET     = 8'h00;

    // Protect delay: time as printed, cycles derived from the clock rate
    localparam int          PFR_CLK_MHZ         = 100;
    localparam int          PFR_PROTECT_DELAY_US = 5000;
    localparam int          PFR_PROTECT_DELAY_CYC = PFR_PROTECT_DELAY_US * PFR_CLK_MHZ;
    localparam int          PFR_TIMER_W         = 20;

    // Pin synchroniser lanes
    localparam int          PFR_SYNC_LANES      = 3;
    localparam int          PFR_LANE_AC_LOW     = 0;
    localparam int          PFR_LANE_COLD_SW    = 1;
    localparam int          PFR_LANE_CLEAR      = 2;

    // Sequencer states
    typedef enum logic [1:0] {
        SEQ_IDLE    = 2'b00,
        SEQ_WAIT    = 2'b01,
        SEQ_PROTECT = 2'b10
    } pfr_seq_state_type;

    // One I/O bus cycle from the processor
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pfr_io_req_type;

    // Read answer toward the processor
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } pfr_io_rsp_type;

endpackage

// File: hw/pfr_delay_timer.sv
`timescale 1ns/1ns
module pfr_delay_timer
    import pfr_pkg::*;
#(
    parameter logic [PFR_TIMER_W-1:0] DELAY_CYCLES = PFR_TIMER_W'(PFR_PROTECT_DELAY_CYC)
) (
    input  wire logic core_clk,
    input  wire logic por,
    input  wire logic start,
    input  wire logic clear,
    output logic      expired
);

    logic [PFR_TIMER_W-1:0] count_q;
    logic [PFR_TIMER_W-1:0] count_d;
    logic                   run_q;
    logic                   run_d;
    logic                   expired_q;
    logic                   expired_d;

    // Count from the event; clear aborts, a fresh start wins over it
    always_comb begin
        count_d   = count_q;
        run_d     = run_q;
        expired_d = 1'b0;
        if (start) begin
            count_d = PFR_TIMER_W'(1);
            run_d   = 1'b1;
        end else if (clear) begin
            count_d = '0;
            run_d   = 1'b0;
        end else if (run_q) begin
            if (count_q >= DELAY_CYCLES) begin
                run_d     = 1'b0;
                expired_d = 1'b1;
            end else begin
                count_d = count_q + PFR_TIMER_W'(1);
            end
        end
    end

    // Only the battery power-on reset touches this; system reset does not
    always_ff @(posedge core_clk) begin
        if (por) begin
            count_q   <= '0;
            run_q     <= 1'b0;
            expired_q <= 1'b0;
        end else begin
            count_q   <= count_d;
            run_q     <= run_d;
            expired_q <= expired_d;
        end
    end

    assign expired = expired_q;

endmodule

// File: hw/pfr_sequencer.sv
`timescale 1ns/1ns
module pfr_sequencer
    import pfr_pkg::*;
#(
    parameter logic [PFR_TIMER_W-1:0] PROTECT_DELAY_CYCLES = PFR_TIMER_W'(PFR_PROTECT_DELAY_CYC)
) (
    input  wire logic           core_clk,
    input  wire logic           rst,
    input  wire logic           battery_por,
    input  wire logic           ac_low_indicator,
    input  wire logic           cold_start_switch,
    input  wire logic           sense_clear,
    input  wire pfr_io_req_type io_req,
    output pfr_io_rsp_type      io_rsp,
    input  wire logic           ram_select_req,
    output logic                ram_select,
    output logic                interrupt_input_zero,
    output logic                power_fail_sense,
    output logic                memory_protect
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [PFR_SYNC_LANES-1:0] pin_raw;
    logic [PFR_SYNC_LANES-1:0] sync1_q;
    logic [PFR_SYNC_LANES-1:0] sync2_q;
    logic                      ac_low_last_q;

    assign pin_raw[PFR_LANE_AC_LOW]  = ac_low_indicator;
    assign pin_raw[PFR_LANE_COLD_SW] = cold_start_switch;
    assign pin_raw[PFR_LANE_CLEAR]   = sense_clear;

    // Two flops per pin; first stage feeds only the second
    genvar g;
    generate
        for (g = 0; g < PFR_SYNC_LANES; g++) begin : g_sync
            always_ff @(posedge core_clk) begin
                if (battery_por) begin
                    sync1_q[g] <= 1'b0;
                    sync2_q[g] <= 1'b0;
                end else begin
                    sync1_q[g] <= pin_raw[g];
                    sync2_q[g] <= sync1_q[g];
                end
            end
        end
    endgenerate

    // Edge history for the low-line indicator
    always_ff @(posedge core_clk) begin
        if (battery_por) begin
            ac_low_last_q <= 1'b0;
        end else begin
            ac_low_last_q <= sync2_q[PFR_LANE_AC_LOW];
        end
    end

    logic ac_low_s;
    logic cold_sw_s;
    logic clear_s;
    logic fail_event;

    assign ac_low_s   = sync2_q[PFR_LANE_AC_LOW];
    assign cold_sw_s  = sync2_q[PFR_LANE_COLD_SW];
    assign clear_s    = sync2_q[PFR_LANE_CLEAR];
    assign fail_event = ac_low_s & ~ac_low_last_q;

    ////////////////////////////////////////////////////////////////////////
    // Port decode

    logic port_hit;
    logic port_wr;
    logic port_rd;

    assign port_hit = (io_req.addr == PFR_PORT_ADDR);
    assign port_wr  = io_req.wr & port_hit;
    assign port_rd  = io_req.rd & port_hit;

    ////////////////////////////////////////////////////////////////////////
    // Protect delay timer

    logic delay_expired;

    pfr_delay_timer #(
        .DELAY_CYCLES (PROTECT_DELAY_CYCLES)
    ) u_delay (
        .core_clk (core_clk),
        .por      (battery_por),
        .start    (fail_event),
        .clear    (clear_s),
        .expired  (delay_expired)
    );

    ////////////////////////////////////////////////////////////////////////
    // Latches and protect sequence

    logic              irq_latch_q;
    logic              irq_latch_d;
    logic              sense_q;
    logic              sense_d;
    pfr_seq_state_type state_q;
    pfr_seq_state_type state_d;

    // Set beats clear for both latches
    always_comb begin
        irq_latch_d = irq_latch_q;
        sense_d     = sense_q;
        if (fail_event) begin
            irq_latch_d = 1'b1;
        end else if (clear_s || port_wr) begin
            irq_latch_d = 1'b0;
        end
        if (fail_event || cold_sw_s) begin
            sense_d = 1'b1;
        end else if (clear_s) begin
            sense_d = 1'b0;
        end
    end

    // Idle, wait out the delay, then protect until sense-clear
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            SEQ_IDLE: begin
                if (fail_event) begin
                    state_d = SEQ_WAIT;
                end
            end
            SEQ_WAIT: begin
                if (fail_event) begin
                    state_d = SEQ_WAIT;
                end else if (clear_s) begin
                    state_d = SEQ_IDLE;
                end else if (delay_expired) begin
                    state_d = SEQ_PROTECT;
                end
            end
            SEQ_PROTECT: begin
                if (fail_event) begin
                    state_d = SEQ_PROTECT;
                end else if (clear_s) begin
                    state_d = SEQ_IDLE;
                end
            end
            default: begin
                state_d = SEQ_IDLE;
            end
        endcase
    end

    // Battery domain state: system reset deliberately absent
    always_ff @(posedge core_clk) begin
        if (battery_por) begin
            irq_latch_q <= 1'b0;
            sense_q     <= 1'b0;
            state_q     <= SEQ_IDLE;
        end else begin
            irq_latch_q <= irq_latch_d;
            sense_q     <= sense_d;
            state_q     <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path

    pfr_io_rsp_type rsp_q;
    pfr_io_rsp_type rsp_d;

    // Sense on the low data line; unmapped reads give no answer
    always_comb begin
        rsp_d.valid = port_rd;
        rsp_d.data  = PFR_RDATA_RESET;
        if (port_rd) begin
            rsp_d.data[PFR_SENSE_BIT] = sense_q;
        end
    end

    // Bus-facing flops follow system reset
    always_ff @(posedge core_clk) begin
        if (rst || battery_por) begin
            rsp_q <= '0;
        end else begin
            rsp_q <= rsp_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign io_rsp               = rsp_q;
    assign interrupt_input_zero = irq_latch_q;
    assign power_fail_sense     = sense_q;
    assign memory_protect       = (state_q == SEQ_PROTECT);
    assign ram_select           = ram_select_req & ~memory_protect;

endmodule

// File: verification/pfr_sequencer_sva.sv
`timescale 1ns/1ns
module pfr_sequencer_sva
    import pfr_pkg::*;
#(
    parameter logic [PFR_TIMER_W-1:0] PROTECT_DELAY_CYCLES = PFR_TIMER_W'(20)
) (
    input wire logic           core_clk,
    input wire logic           rst,
    input wire logic           battery_por,
    input wire logic           ac_low_indicator,
    input wire logic           cold_start_switch,
    input wire logic           sense_clear,
    input wire pfr_io_req_type io_req,
    input wire pfr_io_rsp_type io_rsp,
    input wire logic           ram_select_req,
    input wire logic           ram_select,
    input wire logic           interrupt_input_zero,
    input wire logic           power_fail_sense,
    input wire logic           memory_protect
);
    localparam int DLY_LO = int'(PROTECT_DELAY_CYCLES) - 4;
    wire logic rd_port = io_req.rd && io_req.addr == PFR_PORT_ADDR;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (battery_por);
    // Pin rise held long enough to pass the synchroniser
    sequence s_fail_rise;
        !ac_low_indicator ##1 ac_low_indicator [*3];
    endsequence
    property p_fail_latch;
        s_fail_rise |-> ##[1:3] (interrupt_input_zero && power_fail_sense);
    endproperty
    a_fail_latch: assert property (p_fail_latch) else $error("latches not set");
    property p_protect_delay;
        $rose(interrupt_input_zero) && !memory_protect |-> ##DLY_LO !memory_protect ##[1:8] memory_protect;
    endproperty
    a_protect_delay: assert property (p_protect_delay) else $error("protect delay wrong");
    property p_ram_guard;
        ram_select == (ram_select_req && !memory_protect);
    endproperty
    a_ram_guard: assert property (p_ram_guard) else $error("ram select not gated");
    property p_clear_all;
        (sense_clear && !cold_start_switch && !ac_low_indicator) [*6]
            |-> !(interrupt_input_zero || power_fail_sense || memory_protect);
    endproperty
    a_clear_all: assert property (p_clear_all) else $error("clear incomplete");
    property p_cold_force;
        cold_start_switch [*5] |-> power_fail_sense;
    endproperty
    a_cold_force: assert property (p_cold_force) else $error("cold switch ignored");
    property p_read_sense;
        rd_port |=> io_rsp.valid && io_rsp.data == {7'h00, $past(power_fail_sense)};
    endproperty
    a_read_sense: assert property (p_read_sense) else $error("bad port read");
    property p_read_other;
        !rd_port |=> io_rsp == '0;
    endproperty
    a_read_other: assert property (p_read_other) else $error("stray answer");
    property p_reset_hold;
        rst && interrupt_input_zero && power_fail_sense && !io_req.wr && !sense_clear
            && !$past(sense_clear) && !$past(sense_clear, 2) |=> interrupt_input_zero && power_fail_sense;
    endproperty
    a_reset_hold: assert property (p_reset_hold) else $error("reset cleared latch");
endmodule
bind pfr_sequencer pfr_sequencer_sva #(.PROTECT_DELAY_CYCLES(PROTECT_DELAY_CYCLES)) u_sva (
    .core_clk, .rst, .battery_por, .ac_low_indicator, .cold_start_switch, .sense_clear, .io_req,
    .io_rsp, .ram_select_req, .ram_select, .interrupt_input_zero, .power_fail_sense, .memory_protect
);

// File: verification/pfr_cpu_model.sv
`timescale 1ns/1ns
module pfr_cpu_model
    import pfr_pkg::*;
(
    input  wire logic           core_clk,
    input  wire pfr_io_rsp_type io_rsp,
    output pfr_io_req_type      io_req,
    output logic                sense_clear
);
    logic [7:0] rdata;
    logic       rvalid;
    // Quiet bus and released port bit
    initial begin
        io_req = '0;
        sense_clear = 1'b0;
    end
    // One I/O cycle, answer taken at the edge after the request
    task automatic io_cycle(input logic rd, input logic [7:0] addr, input logic [7:0] wdata);
        @(posedge core_clk);
        #1 io_req = {rd, !rd, addr, wdata};
        @(posedge core_clk);
        #1 io_req = '0;
        rvalid = io_rsp.valid;
        rdata = io_rsp.data;
    endtask
    // Parallel port bit drives the clear line
    task automatic drive_clear(input int cycles);
        @(posedge core_clk);
        #1 sense_clear = 1'b1;
        repeat (cycles) @(posedge core_clk);
        #1 sense_clear = 1'b0;
    endtask
endmodule

// File: verification/power_fail_restart_sequencer_tb_top.sv
`timescale 1ns/1ns
module power_fail_restart_sequencer_tb_top
    import pfr_pkg::*;
;
    localparam logic [PFR_TIMER_W-1:0] DLY = PFR_TIMER_W'(20);
    logic           core_clk = 1'b0;
    logic           rst = 1'b1;
    logic           battery_por = 1'b1;
    logic           ac_low_indicator = 1'b0;
    logic           cold_start_switch = 1'b0;
    logic           ram_select_req = 1'b0;
    logic           exp_prot = 1'b0;
    logic           ram_on = 1'b0;
    logic           sense_clear;
    logic           ram_select;
    logic           interrupt_input_zero;
    logic           power_fail_sense;
    logic           memory_protect;
    pfr_io_req_type io_req;
    pfr_io_rsp_type io_rsp;
    logic [7:0]     addr;
    int             seed = 32'h3442;
    int             mismatches = 0;
    int             check_count = 0;
    int             cycles = 0;
    always #5 core_clk = ~core_clk;
    pfr_sequencer #(.PROTECT_DELAY_CYCLES(DLY)) DUT (
        .core_clk, .rst, .battery_por, .ac_low_indicator, .cold_start_switch, .sense_clear, .io_req,
        .io_rsp, .ram_select_req, .ram_select, .interrupt_input_zero, .power_fail_sense, .memory_protect
    );
    pfr_cpu_model cpu (.core_clk, .io_rsp, .io_req, .sense_clear);
    function automatic logic f_ram(input logic req, input logic prot);
        return req & ~prot;
    endfunction
    function automatic logic [7:0] f_read(input logic sense);
        return {7'h00, sense};
    endfunction
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic end_of_test();
        if (mismatches == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Cycles with random decoder requests
    task automatic step(input int n);
        repeat (n) begin
            @(posedge core_clk);
            #1 if (ram_on) chk("ram_select", f_ram(ram_select_req, exp_prot), ram_select);
            ram_select_req = 1'($random(seed));
        end
    endtask
    task automatic state(input logic irq, input logic sense, input logic prot);
        chk("interrupt_input_zero", irq, interrupt_input_zero);
        chk("power_fail_sense", sense, power_fail_sense);
        chk("memory_protect", prot, memory_protect);
    endtask
    task automatic read_port(input logic sense);
        cpu.io_cycle(1'b1, PFR_PORT_ADDR, 8'h00);
        chk("read_valid", 8'h01, 8'(cpu.rvalid));
        chk("read_data", f_read(sense), cpu.rdata);
    endtask
    // Hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            end_of_test();
        end
    end
    initial begin
        step(3);
        battery_por = 1'b0;
        rst = 1'b0;
        ram_on = 1'b1;
        state(0, 0, 0);
        read_port(0);
        // Random traffic to other ports gets no answer
        repeat (20) begin
            addr = 8'($random(seed));
            if (addr == PFR_PORT_ADDR) addr = 8'hd5;
            cpu.io_cycle(1'($random(seed)), addr, 8'($random(seed)));
            chk("unmapped_valid", 8'h00, 8'(cpu.rvalid));
        end
        // Cold start switch, clear refused while held
        cold_start_switch = 1'b1;
        step(6);
        read_port(1);
        cpu.drive_clear(6);
        read_port(1);
        cold_start_switch = 1'b0;
        cpu.drive_clear(6);
        read_port(0);
        // Power failure, system reset in mid-run, restart
        ac_low_indicator = 1'b1;
        step(5);
        state(1, 1, 0);
        rst = 1'b1;
        step(3);
        rst = 1'b0;
        state(1, 1, 0);
        read_port(1);
        ac_low_indicator = 1'b0;
        cpu.io_cycle(1'b0, PFR_PORT_ADDR, 8'($random(seed)));
        state(0, 1, 0);
        ram_on = 1'b0;
        step(int'(DLY) + 8);
        exp_prot = 1'b1;
        ram_on = 1'b1;
        step(4);
        state(0, 1, 1);
        ram_on = 1'b0;
        cpu.drive_clear(6);
        exp_prot = 1'b0;
        ram_on = 1'b1;
        state(0, 0, 0);
        step(4);
        end_of_test();
    end
endmodule
